// ==== shared/turbine_trip_pkg.sv ====
`default_nettype none
package turbine_trip_pkg;

	// =====================================================
	// register map (word index on regAddr)
	localparam logic [7:0] ADDR_GAIN     = 8'h00;
	localparam logic [7:0] ADDR_OFFSET   = 8'h01;
	localparam logic [7:0] ADDR_SP_HIGH  = 8'h02;
	localparam logic [7:0] ADDR_SP_LOW   = 8'h03;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_MASK     = 8'h05;
	localparam logic [7:0] ADDR_LIVE     = 8'h06;
	localparam logic [7:0] ADDR_MONITOR  = 8'h07;

	// =====================================================
	// status / mask bit positions
	localparam int ST_FAIL = 0;
	localparam int ST_HIGH = 1;
	localparam int ST_LOW  = 2;
	localparam int ST_W    = 3;

	// live register field positions
	localparam int LIVE_HIGH   = 17;
	localparam int LIVE_LOW    = 18;
	localparam int LIVE_FAIL   = 19;
	localparam int LIVE_BYPASS = 20;

	// =====================================================
	// sensor input, microamps per code
	localparam logic [15:0] IN_ZERO   = 16'h0FA0; // 4000 uA
	localparam logic [15:0] IN_TOP    = 16'h4E20; // 20000 uA
	localparam logic [15:0] FAIL_LOW  = 16'h0ED8; // 3800 uA
	localparam logic [15:0] FAIL_HIGH = 16'h4EE8; // 20200 uA

	// engineering value in 0.001 % of turbine power
	localparam logic [16:0] SCALE_FULL = 17'h1ADB0; // 110.000 %
	localparam logic [19:0] RAW_NUM    = 20'h00037; // 110000/16000 = 55/8
	localparam int          RAW_SHIFT  = 3;

	// gain, unsigned fixed point with 14 fraction bits
	localparam int          GAIN_FRAC  = 14;
	localparam logic [15:0] GAIN_MIN   = 16'h2000; // 0.5000
	localparam logic [15:0] GAIN_MAX   = 16'h7999; // 1.8999
	localparam logic [15:0] GAIN_ONE   = 16'h4000;

	// offset, signed, 0.001 %
	localparam logic [15:0] OFFSET_MIN = 16'hD508; // -11.000 %
	localparam logic [15:0] OFFSET_MAX = 16'h2AF8; // 11.000 %
	localparam logic [15:0] OFFSET_RST = 16'h0000;

	// comparator setpoints, 0.001 %
	localparam logic [16:0] SP_MIN = 17'h01388; // 5.000 %
	localparam logic [16:0] SP_MAX = 17'h04E20; // 20.000 %
	localparam logic [16:0] SP_RST = 17'h02710; // 10.000 %

	// monitor output: uA = 4000 + value * 19066 / 2^17
	localparam logic [31:0] MON_RECIP = 32'h00004A7A;
	localparam int          MON_SHIFT = 17;

	// =====================================================
	typedef struct packed {
		logic        failure;
		logic [16:0] scaled;
	} chanState_t;

endpackage
`default_nettype wire

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	input  wire logic clk_sys,  // system clock
	input  wire logic rst_n,    // async reset, active low
	input  wire logic pinIn,    // asynchronous pin
	output logic      levelOut  // filtered level
);

	logic s1Q, s2Q, s3Q, outQ;
	logic outD;

	// =====================================================
	// three stages; only accept once stages two and three agree
	always_comb begin
		outD = (s2Q == s3Q) ? s3Q : outQ;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1Q  <= 1'b0;
			s2Q  <= 1'b0;
			s3Q  <= 1'b0;
			outQ <= 1'b0;
		end else begin
			s1Q  <= pinIn;
			s2Q  <= s1Q;
			s3Q  <= s2Q;
			outQ <= outD;
		end
	end

	assign levelOut = outQ;

endmodule
`default_nettype wire

// ==== design/trip_comparator.sv ====
`timescale 1ns/10ps
`default_nettype none
module trip_comparator (
	input  wire logic        clk_sys,    // system clock
	input  wire logic        rst_n,      // async reset, active low
	input  wire logic [16:0] value,      // scaled value
	input  wire logic [16:0] setpoint,   // trip point
	input  wire logic        tripAbove,  // 1: trip at or above, 0: trip below
	input  wire logic        bypass,     // hold non-tripped
	output logic             energized   // 1 = not tripped
);

	logic trip;
	logic energizedD;
	logic energizedQ;

	// =====================================================
	always_comb begin
		trip       = tripAbove ? (value >= setpoint) : (value < setpoint); // RULE11
		energizedD = bypass | ~trip; // RULE9
	end

	// de-energized after reset: the safe, tripped state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			energizedQ <= 1'b0;
		end else begin
			energizedQ <= energizedD; // RULE4
		end
	end

	assign energized = energizedQ; // RULE6

endmodule
`default_nettype wire

// ==== design/turbine_pressure_trip_channel.sv ====
// Summary of operation
// RULE1: scale 4-20 mA to 0-110 % power
// RULE2: multiply by gain 0.5000 to 1.9000
// RULE3: add offset between -11 and +11 %
// RULE4: high comparator permissive, de-energized when tripped
// RULE5: high setpoint adjustable 5 to 20 %
// RULE6: low comparator interlock, de-energized when tripped
// RULE7: low setpoint adjustable 5 to 20 %
// RULE8: out-of-range sensor raises failure annunciator
// RULE9: bypass holds high comparator non-tripped
// RULE10: map 0-110 % back to 4-20 mA
// RULE11: high trips at/above, low trips below
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module turbine_pressure_trip_channel (
	input  wire logic        clk_sys,            // 200 MHz clock
	input  wire logic        rst_n,              // async reset, active low
	input  wire logic [15:0] sensorCode,         // sensor current, uA
	input  wire logic        bypassSwitch,       // manual bypass pin
	input  wire logic [7:0]  regAddr,            // register index
	input  wire logic [31:0] regWdata,           // write data
	input  wire logic        regWrite,           // write strobe
	input  wire logic        regRead,            // read strobe
	output logic      [31:0] regRdata,           // read data, next cycle
	output logic             highPermit,         // 1 = not tripped
	output logic             lowInterlock,       // 1 = not tripped
	output logic             failureAnnunciator, // sensor out of range
	output logic      [15:0] monitorCode,        // monitor current, uA
	output logic             irq                 // level interrupt
);

	// =====================================================
	// input stage and scaling
	logic [15:0]                     curQ;
	logic [15:0]                     inClamp;
	logic [15:0]                     inDiff;
	logic [19:0]                     rawProd;
	logic [16:0]                     raw;
	logic [31:0]                     gained;
	logic signed [19:0]              sumS;
	logic                            failNow;
	turbine_trip_pkg::chanState_t    stD;
	turbine_trip_pkg::chanState_t    stQ;
	logic [15:0]                     gainQ, gainD;
	logic [15:0]                     offsetQ, offsetD;
	logic [16:0]                     spHighQ, spHighD;
	logic [16:0]                     spLowQ, spLowD;
	logic [turbine_trip_pkg::ST_W-1:0] statusQ, statusD;
	logic [turbine_trip_pkg::ST_W-1:0] maskQ, maskD;
	logic [turbine_trip_pkg::ST_W-1:0] events;
	logic [31:0]                     rdataD, rdataQ;

	always_comb begin
		failNow = (curQ < turbine_trip_pkg::FAIL_LOW) || (curQ > turbine_trip_pkg::FAIL_HIGH); // RULE8
		if (curQ < turbine_trip_pkg::IN_ZERO) begin
			inClamp = turbine_trip_pkg::IN_ZERO;
		end else if (curQ > turbine_trip_pkg::IN_TOP) begin
			inClamp = turbine_trip_pkg::IN_TOP;
		end else begin
			inClamp = curQ;
		end
		inDiff  = inClamp - turbine_trip_pkg::IN_ZERO;
		rawProd = 20'({4'h0, inDiff} * turbine_trip_pkg::RAW_NUM);
		raw     = 17'(rawProd >> turbine_trip_pkg::RAW_SHIFT); // RULE1
		gained  = 32'({15'h0000, raw} * {16'h0000, gainQ}); // RULE2
		sumS    = $signed({2'b00, gained[31:turbine_trip_pkg::GAIN_FRAC]})
		        + $signed({{4{offsetQ[15]}}, offsetQ}); // RULE3
		stD.failure = failNow;
		// clamp keeps the value inside the 0 to 110 % span
		if (sumS < 20'sh00000) begin
			stD.scaled = 17'h00000;
		end else if (sumS > $signed({3'b000, turbine_trip_pkg::SCALE_FULL})) begin
			stD.scaled = turbine_trip_pkg::SCALE_FULL; // RULE1
		end else begin
			stD.scaled = sumS[16:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// idle at 4 mA, so leaving reset never fakes a sensor failure
			curQ <= turbine_trip_pkg::IN_ZERO;
			stQ  <= '0;
		end else begin
			curQ <= sensorCode;
			stQ  <= stD;
		end
	end

	// =====================================================
	// comparators and bypass
	logic bypassSync;
	logic highEnergized;
	logic lowEnergized;

	pin_sync bypassSyncInst (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pinIn    (bypassSwitch),
		.levelOut (bypassSync)
	);

	trip_comparator highComp (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.value     (stQ.scaled),
		.setpoint  (spHighQ),
		.tripAbove (1'b1),
		.bypass    (bypassSync), // RULE9
		.energized (highEnergized)
	);

	// low comparator has no bypass; its supply voltage is external
	trip_comparator lowComp (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.value     (stQ.scaled),
		.setpoint  (spLowQ),
		.tripAbove (1'b0),
		.bypass    (1'b0),
		.energized (lowEnergized)
	);

	assign highPermit         = highEnergized; // RULE4
	assign lowInterlock       = lowEnergized; // RULE6
	assign failureAnnunciator = stQ.failure; // RULE8

	// =====================================================
	// monitor output
	logic [15:0] monD;
	logic [15:0] monQ;
	logic [31:0] monProd;

	always_comb begin
		monProd = 32'({15'h0000, stQ.scaled} * turbine_trip_pkg::MON_RECIP);
		monD    = turbine_trip_pkg::IN_ZERO + 16'(monProd >> turbine_trip_pkg::MON_SHIFT); // RULE10
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			monQ <= turbine_trip_pkg::IN_ZERO;
		end else begin
			monQ <= monD;
		end
	end

	assign monitorCode = monQ;

	// =====================================================
	// register file

	// out-of-range writes saturate, so settings never leave their span
	function automatic logic [16:0] satU17(input logic [31:0] v, input logic [16:0] lo, input logic [16:0] hi);
		if (v < {15'h0000, lo}) begin
			satU17 = lo;
		end else if (v > {15'h0000, hi}) begin
			satU17 = hi;
		end else begin
			satU17 = v[16:0];
		end
	endfunction

	function automatic logic [15:0] satS16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		if ($signed(v) < $signed(lo)) begin
			satS16 = lo;
		end else if ($signed(v) > $signed(hi)) begin
			satS16 = hi;
		end else begin
			satS16 = v;
		end
	endfunction

	always_comb begin
		gainD   = gainQ;
		offsetD = offsetQ;
		spHighD = spHighQ;
		spLowD  = spLowQ;
		maskD   = maskQ;
		events  = '0;
		events[turbine_trip_pkg::ST_FAIL] = stQ.failure;
		events[turbine_trip_pkg::ST_HIGH] = ~highEnergized;
		events[turbine_trip_pkg::ST_LOW]  = ~lowEnergized;
		statusD = statusQ;
		if (regWrite) begin
			case (regAddr)
				turbine_trip_pkg::ADDR_GAIN: begin
					gainD = 16'(satU17({16'h0000, regWdata[15:0]}, {1'b0, turbine_trip_pkg::GAIN_MIN},
					                   {1'b0, turbine_trip_pkg::GAIN_MAX})); // RULE2
				end
				turbine_trip_pkg::ADDR_OFFSET: begin
					offsetD = satS16(regWdata[15:0], turbine_trip_pkg::OFFSET_MIN,
					                 turbine_trip_pkg::OFFSET_MAX); // RULE3
				end
				turbine_trip_pkg::ADDR_SP_HIGH: begin
					spHighD = satU17(regWdata, turbine_trip_pkg::SP_MIN, turbine_trip_pkg::SP_MAX); // RULE5
				end
				turbine_trip_pkg::ADDR_SP_LOW: begin
					spLowD = satU17(regWdata, turbine_trip_pkg::SP_MIN, turbine_trip_pkg::SP_MAX); // RULE7
				end
				turbine_trip_pkg::ADDR_STATUS: begin
					statusD = statusQ & ~regWdata[turbine_trip_pkg::ST_W-1:0];
				end
				turbine_trip_pkg::ADDR_MASK: begin
					maskD = regWdata[turbine_trip_pkg::ST_W-1:0];
				end
				default: begin
					gainD = gainQ;
				end
			endcase
		end
		// set after clear: an event in the clearing cycle survives
		statusD = statusD | events;
		rdataD = 32'h00000000;
		if (regRead) begin
			case (regAddr)
				turbine_trip_pkg::ADDR_GAIN:    rdataD = {16'h0000, gainQ};
				turbine_trip_pkg::ADDR_OFFSET:  rdataD = {16'h0000, offsetQ};
				turbine_trip_pkg::ADDR_SP_HIGH: rdataD = {15'h0000, spHighQ};
				turbine_trip_pkg::ADDR_SP_LOW:  rdataD = {15'h0000, spLowQ};
				turbine_trip_pkg::ADDR_STATUS:  rdataD = {29'h00000000, statusQ};
				turbine_trip_pkg::ADDR_MASK:    rdataD = {29'h00000000, maskQ};
				turbine_trip_pkg::ADDR_LIVE: begin
					rdataD = {11'h000, bypassSync, stQ.failure, lowEnergized, highEnergized, stQ.scaled};
				end
				turbine_trip_pkg::ADDR_MONITOR: rdataD = {16'h0000, monQ};
				default:                        rdataD = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gainQ   <= turbine_trip_pkg::GAIN_ONE;
			offsetQ <= turbine_trip_pkg::OFFSET_RST;
			spHighQ <= turbine_trip_pkg::SP_RST;
			spLowQ  <= turbine_trip_pkg::SP_RST;
			statusQ <= '0;
			maskQ   <= '0;
			rdataQ  <= 32'h00000000;
		end else begin
			gainQ   <= gainD;
			offsetQ <= offsetD;
			spHighQ <= spHighD;
			spLowQ  <= spLowD;
			statusQ <= statusD;
			maskQ   <= maskD;
			rdataQ  <= rdataD;
		end
	end

	assign regRdata = rdataQ;
	assign irq      = |(statusQ & maskQ);

	// =====================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_fullScale;
		(curQ == turbine_trip_pkg::IN_TOP && gainQ == turbine_trip_pkg::GAIN_ONE && offsetQ == 16'h0000)
		|=> (stQ.scaled == turbine_trip_pkg::SCALE_FULL);
	endproperty
	a_fullScale: assert property (p_fullScale) else $error("full input not at 110 percent"); // RULE1

	property p_gainRange;
		regWrite ##1 1'b1 |-> (gainQ >= turbine_trip_pkg::GAIN_MIN && gainQ <= turbine_trip_pkg::GAIN_MAX);
	endproperty
	a_gainRange: assert property (p_gainRange) else $error("gain outside range"); // RULE2

	property p_offsetRange;
		regWrite |=> ($signed(offsetQ) >= $signed(turbine_trip_pkg::OFFSET_MIN)
		          && $signed(offsetQ) <= $signed(turbine_trip_pkg::OFFSET_MAX));
	endproperty
	a_offsetRange: assert property (p_offsetRange) else $error("offset outside range"); // RULE3

	property p_highTrip;
		(stQ.scaled >= spHighQ && !bypassSync) |=> !highPermit;
	endproperty
	a_highTrip: assert property (p_highTrip) else $error("high comparator did not trip"); // RULE4

	property p_spHighRange;
		regWrite |=> (spHighQ >= turbine_trip_pkg::SP_MIN && spHighQ <= turbine_trip_pkg::SP_MAX);
	endproperty
	a_spHighRange: assert property (p_spHighRange) else $error("high setpoint outside range"); // RULE5

	property p_lowTrip;
		(stQ.scaled < spLowQ) |=> !lowInterlock;
	endproperty
	a_lowTrip: assert property (p_lowTrip) else $error("low comparator did not trip"); // RULE6

	property p_spLowRange;
		regWrite |=> (spLowQ >= turbine_trip_pkg::SP_MIN && spLowQ <= turbine_trip_pkg::SP_MAX);
	endproperty
	a_spLowRange: assert property (p_spLowRange) else $error("low setpoint outside range"); // RULE7

	property p_failure;
		(sensorCode < turbine_trip_pkg::FAIL_LOW) ##1 (curQ < turbine_trip_pkg::FAIL_LOW) |=> failureAnnunciator;
	endproperty
	a_failure: assert property (p_failure) else $error("failure annunciator missing"); // RULE8

	property p_bypass;
		bypassSync |=> highPermit;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not hold permissive"); // RULE9

	property p_monitor;
		(stQ.scaled == 17'h00000) ##1 1'b1 |-> (monitorCode == turbine_trip_pkg::IN_ZERO);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor zero not at 4 mA"); // RULE10

	property p_lowClear;
		(stQ.scaled >= spLowQ) |=> lowInterlock;
	endproperty
	a_lowClear: assert property (p_lowClear) else $error("low comparator tripped at setpoint"); // RULE11

	property p_stickySet;
		(stQ.failure && regWrite && regAddr == turbine_trip_pkg::ADDR_STATUS)
		|=> statusQ[turbine_trip_pkg::ST_FAIL];
	endproperty
	a_stickySet: assert property (p_stickySet) else $error("event lost on clear"); // RULE8

	c_highTrip: cover property (!bypassSync ##1 !highPermit);
	c_bypassHigh: cover property (bypassSync && stQ.scaled >= spHighQ ##1 highPermit);
	c_failure: cover property ($rose(failureAnnunciator));
	c_irq: cover property ($rose(irq));

endmodule
`default_nettype wire

// ==== verif/trip_logic_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// far side: trip actuation logic, control room lamps and the bypass switch
module trip_logic_model (
	input  wire logic clk_sys,            // system clock
	input  wire logic rst_n,              // async reset, active low
	input  wire logic highPermit,         // high comparator, 1 = energized
	input  wire logic lowInterlock,       // low comparator, 1 = energized
	input  wire logic failureAnnunciator, // channel failure request
	input  wire logic bypassReq,          // operator turns the switch
	output logic      bypassSwitch,       // switch contact to the channel
	output logic      permitTripped,      // trip logic sees permissive tripped
	output logic      interlockTripped,   // trip logic sees interlock tripped
	output logic      failureLamp         // failure lamp lit
);
	// =====================================================
	// switch contact is a steady level, moved only after an edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bypassSwitch <= 1'b0;
		end else begin
			bypassSwitch <= bypassReq;
		end
	end

	// =====================================================
	// de-energized input reads as tripped; a dead line must trip too
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			permitTripped    <= 1'b1;
			interlockTripped <= 1'b1;
			failureLamp      <= 1'b0;
		end else begin
			permitTripped    <= ~highPermit;
			interlockTripped <= ~lowInterlock;
			failureLamp      <= failureAnnunciator;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_sys;
	logic        rst_n;
	logic [15:0] sensorCode;
	logic        bypassSwitch;
	logic        bypassReq;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic        regWrite;
	logic        regRead;
	logic [31:0] regRdata;
	logic        highPermit;
	logic        lowInterlock;
	logic        failureAnnunciator;
	logic [15:0] monitorCode;
	logic        irq;
	logic        permitTripped;
	logic        interlockTripped;
	logic        failureLamp;
	logic [15:0] rnd;
	logic [31:0] rv;
	int          numErrors;
	int          checkCount;
	int          cycles;

	turbine_pressure_trip_channel dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .sensorCode(sensorCode), .bypassSwitch(bypassSwitch),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .highPermit(highPermit), .lowInterlock(lowInterlock),
		.failureAnnunciator(failureAnnunciator), .monitorCode(monitorCode), .irq(irq));

	trip_logic_model far (
		.clk_sys(clk_sys), .rst_n(rst_n), .highPermit(highPermit), .lowInterlock(lowInterlock),
		.failureAnnunciator(failureAnnunciator), .bypassReq(bypassReq), .bypassSwitch(bypassSwitch),
		.permitTripped(permitTripped), .interlockTripped(interlockTripped), .failureLamp(failureLamp));

	// =====================================================
	// expectation helpers
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int nxt();
		rnd = lfsr(rnd);
		return int'(rnd);
	endfunction

	function automatic int scl(int i, int g, int o);
		longint r;
		if (i < 4000) i = 4000;
		if (i > 20000) i = 20000;
		r = ((i - 4000) * 55) >>> 3;
		r = ((r * g) >>> 14) + o;
		if (r < 0) r = 0;
		if (r > 110000) r = 110000;
		return int'(r);
	endfunction

	// =====================================================
	// bus and compare tasks
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask

	task automatic apply(int i, int g, int o, int sh, int sl);
		int s;
		int mon;
		wr(turbine_trip_pkg::ADDR_GAIN, 32'(g));
		wr(turbine_trip_pkg::ADDR_OFFSET, {16'h0000, 16'(o)});
		wr(turbine_trip_pkg::ADDR_SP_HIGH, 32'(sh));
		wr(turbine_trip_pkg::ADDR_SP_LOW, 32'(sl));
		sensorCode <= 16'(i);
		repeat (5) @(posedge clk_sys);
		#1;
		s = scl(i, g, o);
		mon = 4000 + int'((longint'(s) * 19066) >>> 17);
		chk("highPermit", 32'(highPermit), 32'(s < sh));
		chk("lowInterlock", 32'(lowInterlock), 32'(s >= sl));
		chk("failure", 32'(failureAnnunciator), 32'(i < 3800 || i > 20200));
		chk("monitorCode", 32'(monitorCode), 32'(mon));
		chk("farSide", {29'h0, permitTripped, interlockTripped, failureLamp},
			{29'h0, 1'(s >= sh), 1'(s < sl), 1'(i < 3800 || i > 20200)});
		rd(turbine_trip_pkg::ADDR_LIVE, rv);
		chk("live", rv, {11'h000, 1'b0, 1'(i < 3800 || i > 20200), 1'(s >= sl), 1'(s < sh), 17'(s)});
	endtask

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// =====================================================
	// clock and hang guard; the run needs under a thousand cycles
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			tallyAndFinish();
		end
	end

	// =====================================================
	// main sequence
	initial begin
		logic [7:0]  sa [6];
		logic [31:0] sw [6];
		logic [31:0] se [6];
		numErrors = 0;
		checkCount = 0;
		cycles = 0;
		rnd = 16'h09FD;
		rst_n = 1'b0;
		sensorCode = 16'h0FA0;
		bypassReq = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0000_0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (7) @(posedge clk_sys);
		#1;
		chk("rstHigh", 32'(highPermit), 32'h0);
		chk("rstLow", 32'(lowInterlock), 32'h0);
		chk("rstMon", 32'(monitorCode), 32'h0FA0);
		chk("rstIrq", 32'(irq), 32'h0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		rd(turbine_trip_pkg::ADDR_GAIN, rv);
		chk("gainRst", rv, 32'h4000);
		chk("rstFail", 32'(failureAnnunciator), 32'h0);
		rd(turbine_trip_pkg::ADDR_SP_LOW, rv);
		chk("spLowRst", rv, 32'h2710);
		// saturation at the setting limits
		sa = '{turbine_trip_pkg::ADDR_GAIN, turbine_trip_pkg::ADDR_GAIN, turbine_trip_pkg::ADDR_OFFSET,
			turbine_trip_pkg::ADDR_OFFSET, turbine_trip_pkg::ADDR_SP_HIGH, turbine_trip_pkg::ADDR_SP_LOW};
		sw = '{32'hFFFF, 32'h0000, 32'h4E20, 32'hB1E0, 32'h0000, 32'h7530};
		se = '{32'h7999, 32'h2000, 32'h2AF8, 32'hD508, 32'h1388, 32'h4E20};
		foreach (sa[k]) begin
			wr(sa[k], sw[k]);
			rd(sa[k], rv);
			chk("saturate", rv, se[k]);
		end
		wr(8'h10, 32'h1234);
		rd(8'h10, rv);
		chk("unmapped", rv, 32'h0);
		// corners: full scale, equality, failure thresholds, clamps
		apply(20000, 16384, 0, 10000, 10000);
		apply(5600, 16384, 0, 11000, 11000);
		apply(3800, 16384, 0, 5000, 5000);
		apply(3799, 16384, 0, 5000, 5000);
		apply(20200, 31129, 11000, 20000, 20000);
		apply(20201, 8192, -11000, 5000, 20000);
		apply(4500, 8192, -11000, 5000, 5000);
		repeat (40) begin
			apply(3000 + nxt() % 18500, 8192 + nxt() % 22938, nxt() % 22001 - 11000,
				5000 + nxt() % 15001, 5000 + nxt() % 15001);
		end
		// bypass holds the permissive energized
		apply(20000, 16384, 0, 10000, 10000);
		bypassReq <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("bypassOn", 32'(highPermit), 32'h1);
		rd(turbine_trip_pkg::ADDR_LIVE, rv);
		chk("liveBypass", 32'(rv[turbine_trip_pkg::LIVE_BYPASS]), 32'h1);
		bypassReq <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("bypassOff", 32'(highPermit), 32'h0);
		// failure interrupt: sticky, cleared by one, masked
		wr(turbine_trip_pkg::ADDR_STATUS, 32'h7);
		wr(turbine_trip_pkg::ADDR_MASK, 32'h1);
		sensorCode <= 16'h0BB8;
		@(posedge clk_sys);
		#1;
		chk("irqIdle", 32'(irq), 32'h0);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("irqSet", 32'(irq), 32'h1);
		@(posedge clk_sys);
		sensorCode <= 16'h2EE0;
		repeat (5) @(posedge clk_sys);
		#1;
		chk("irqSticky", 32'(irq), 32'h1);
		wr(turbine_trip_pkg::ADDR_STATUS, 32'h1);
		@(posedge clk_sys);
		#1;
		chk("irqClear", 32'(irq), 32'h0);
		wr(turbine_trip_pkg::ADDR_MASK, 32'h0);
		sensorCode <= 16'h0BB8;
		repeat (5) @(posedge clk_sys);
		#1;
		chk("irqMasked", 32'(irq), 32'h0);
		rd(turbine_trip_pkg::ADDR_STATUS, rv);
		chk("statusFail", 32'(rv[turbine_trip_pkg::ST_FAIL]), 32'h1);
		chk("statusLow", 32'(rv[turbine_trip_pkg::ST_LOW]), 32'h1);
		// clearing while the sensor still fails: the event must win
		wr(turbine_trip_pkg::ADDR_STATUS, 32'h1);
		rd(turbine_trip_pkg::ADDR_STATUS, rv);
		chk("setWins", 32'(rv[turbine_trip_pkg::ST_FAIL]), 32'h1);
		tallyAndFinish();
	end
endmodule
`default_nettype wire
